// >>> inc/port_io_pkg.sv
/*
  Shared constants for the port I/O cell block: register byte offsets,
  field positions, reset values and pin numbering.
  Assumes a 32-bit AHB-Lite bus with one aligned word per register.
*/
`default_nettype none

package port_io_pkg;

  // ----------------------------------------------------------------
  // pin numbering
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 16;         // P0.0-P0.7, P1.0-P1.6, P2.7
  localparam int NUM_MIXED = 15;        // pins 0..14 may be analog or digital
  localparam int DEBUG_PIN = 15;        // P2.7, shared with debug data line
  localparam int NUM_CHAN = 4;          // peripheral channels on the pin switch
  localparam int CHAN_W = 2;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ANALOG_DIGITAL = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_MODE = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h08;
  localparam logic [7:0] OFS_DRIVE_STRENGTH = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_PIN_READ = 8'h14;
  localparam logic [7:0] OFS_SWITCH_SKIP = 8'h18;
  localparam logic [7:0] OFS_CHAN_ENABLE = 8'h1c;
  localparam logic [7:0] OFS_CLAIMED = 8'h20;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_SWITCH_EN_BIT = 0;   // pin_switch_enable
  localparam int CTRL_PULLUP_DIS_BIT = 1;  // global_pullup_disable

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ANALOG_DIGITAL = 16'hffff;  // all digital
  localparam logic [15:0] RST_OUTPUT_MODE = 16'h0000;     // open-drain
  localparam logic [15:0] RST_OUTPUT_LATCH = 16'hffff;    // released
  localparam logic [15:0] RST_DRIVE_STRENGTH = 16'h0000;  // low drive
  localparam logic [1:0] RST_CONTROL = 2'h0;
  localparam logic [15:0] RST_SWITCH_SKIP = 16'h0000;
  localparam logic [3:0] RST_CHAN_ENABLE = 4'h0;

  // ----------------------------------------------------------------
  // AHB-Lite codes
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;

endpackage

`default_nettype wire

// >>> src/port_io_cells.sv
/*
  Port I/O cell control for sixteen pins, with a small priority pin switch
  and an AHB-Lite register slave.
  Assumes pads outside resolve level from PAD_OUT_O / PAD_OE_N_O / pull-up
  enable, and that all inputs are synchronous to REF_CLK_I.
*/
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module port_io_cells (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // pads
  input wire logic [15:0] PAD_IN_I,
  output logic [15:0] PAD_OUT_O,
  output logic [15:0] PAD_OE_N_O,
  output logic [15:0] PAD_PULLUP_EN_O,
  output logic [15:0] PAD_RX_EN_O,
  output logic [15:0] PAD_DRIVE_HIGH_O,
  // peripheral channels on the pin switch
  input wire logic [3:0] PERIPH_OUT_I,
  output logic [3:0] PERIPH_IN_O,
  // debug data line sharing P2.7
  input wire logic DEBUG_WIRE_DATA_LINE_OE_I,
  input wire logic DEBUG_WIRE_DATA_LINE_OUT_I,
  output logic DEBUG_WIRE_DATA_LINE_IN_O
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // index of the lowest set bit, used by the pin switch scan
  function automatic logic [1:0] lowest_bit(input logic [3:0] v);
    logic [1:0] idx;
    idx = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (v[k]) begin
        idx = k[1:0];
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] pin_analog_digital_select;
  logic [15:0] pin_output_mode_select;
  logic [15:0] output_latch;
  logic [15:0] pin_drive_strength_select;
  logic pin_switch_enable;
  logic global_pullup_disable;
  logic [15:0] switch_skip;
  logic [3:0] chan_enable;
  logic [15:0] pin_read;

  logic [15:0] next_pin_analog_digital_select;
  logic [15:0] next_pin_output_mode_select;
  logic [15:0] next_output_latch;
  logic [15:0] next_pin_drive_strength_select;
  logic next_pin_switch_enable;
  logic next_global_pullup_disable;
  logic [15:0] next_switch_skip;
  logic [3:0] next_chan_enable;
  logic [15:0] next_pin_read;

  logic dphase_write;
  logic [7:0] dphase_addr;
  logic [31:0] rdata;
  logic next_dphase_write;
  logic [7:0] next_dphase_addr;
  logic [31:0] next_rdata;

  logic [15:0] pad_out;
  logic [15:0] pad_oe_n;
  logic [15:0] pad_pullup;
  logic [15:0] pad_rx;
  logic [15:0] pad_strong;
  logic [3:0] periph_in;
  logic debug_in;
  logic [15:0] next_pad_out;
  logic [15:0] next_pad_oe_n;
  logic [15:0] next_pad_pullup;
  logic [15:0] next_pad_rx;
  logic [15:0] next_pad_strong;
  logic [3:0] next_periph_in;
  logic next_debug_in;

  // pin switch results
  logic [15:0] claimed;
  logic [1:0] claim_chan [16];
  logic [15:0] digital;

  // ----------------------------------------------------------------
  // pin switch: enabled channels, lowest first, take the lowest
  // unskipped digital pins; P2.7 is never offered, it stays GPIO
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] remaining;
    remaining = chan_enable;
    claimed = 16'h0000;
    for (int p = 0; p < port_io_pkg::NUM_PINS; p++) begin
      claim_chan[p] = 2'h0;
    end
    for (int p = 0; p < port_io_pkg::NUM_MIXED; p++) begin
      if (!switch_skip[p] && digital[p] && remaining != 4'h0) begin
        claimed[p] = 1'b1;
        claim_chan[p] = lowest_bit(remaining);
        remaining[lowest_bit(remaining)] = 1'b0;
      end
    end
  end

  // P2.7 has no analog path, so its select bit is forced digital
  assign digital = {1'b1, pin_analog_digital_select[14:0]};

  // ----------------------------------------------------------------
  // pad cell next values
  // ----------------------------------------------------------------
  always_comb begin
    logic val;
    logic drive_low;
    logic drive_high;
    val = 1'b0;
    drive_low = 1'b0;
    drive_high = 1'b0;
    next_periph_in = 4'h0;
    for (int p = 0; p < port_io_pkg::NUM_PINS; p++) begin
      val = claimed[p] ? PERIPH_OUT_I[claim_chan[p]] : output_latch[p];
      // open-drain never drives high and nothing drives until switch on, except the debugger on P2.7
      drive_low = pin_switch_enable && !val;
      drive_high = pin_switch_enable && val && pin_output_mode_select[p];
      if (p == port_io_pkg::DEBUG_PIN && DEBUG_WIRE_DATA_LINE_OE_I) begin
        // debugger owns the pad while it drives the shared line
        drive_low = !DEBUG_WIRE_DATA_LINE_OUT_I;
        drive_high = DEBUG_WIRE_DATA_LINE_OUT_I;
      end
      next_pad_out[p] = drive_high;
      next_pad_oe_n[p] = !(drive_low || drive_high);
      // pull-up only on digital cells not pulled low and not disabled
      next_pad_pullup[p] = digital[p] && !drive_low && !global_pullup_disable;
      next_pad_rx[p] = digital[p];
      next_pad_strong[p] = pin_drive_strength_select[p];
      // analog pins read zero, digital pins read the pad itself
      next_pin_read[p] = PAD_IN_I[p] && digital[p];
      if (claimed[p]) begin
        next_periph_in[claim_chan[p]] = PAD_IN_I[p];
      end
    end
    next_debug_in = PAD_IN_I[port_io_pkg::DEBUG_PIN];
  end

  // pad cell registers; reset leaves every cell released and pulled up
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      pad_out <= 16'h0000;
      pad_oe_n <= 16'hffff;
      pad_pullup <= 16'hffff;
      pad_rx <= 16'hffff;
      pad_strong <= 16'h0000;
      periph_in <= 4'h0;
      debug_in <= 1'b0;
      pin_read <= 16'h0000;
    end else begin
      pad_out <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
      pad_pullup <= next_pad_pullup;
      pad_rx <= next_pad_rx;
      pad_strong <= next_pad_strong;
      periph_in <= next_periph_in;
      debug_in <= next_debug_in;
      pin_read <= next_pin_read;
    end
  end

  assign PAD_OUT_O = pad_out;
  assign PAD_OE_N_O = pad_oe_n;
  assign PAD_PULLUP_EN_O = pad_pullup;
  assign PAD_RX_EN_O = pad_rx;
  assign PAD_DRIVE_HIGH_O = pad_strong;
  assign PERIPH_IN_O = periph_in;
  assign DEBUG_WIRE_DATA_LINE_IN_O = debug_in;

  // ----------------------------------------------------------------
  // ahb-lite slave: zero wait states, read data fetched in the
  // address phase, writes applied in the data phase
  // ----------------------------------------------------------------
  always_comb begin
    logic take;
    take = HSEL_I && HREADY_I && (HTRANS_I == port_io_pkg::HTRANS_NONSEQ ||
                                  HTRANS_I == port_io_pkg::HTRANS_SEQ);
    // writes outside the low 256 bytes are dropped, like the reads
    next_dphase_write = take && HWRITE_I && HADDR_I[31:8] == 24'h000000;
    next_dphase_addr = take ? HADDR_I[7:0] : dphase_addr;
    next_rdata = 32'h0000_0000;
    // unmapped offsets read zero; a read right after a write to the same
    // word sees the old value because the fetch precedes the write
    if (take && !HWRITE_I && HADDR_I[31:8] == 24'h000000) begin
      unique case (HADDR_I[7:0])
        port_io_pkg::OFS_ANALOG_DIGITAL: next_rdata = {16'h0000, digital};
        port_io_pkg::OFS_OUTPUT_MODE: next_rdata = {16'h0000, pin_output_mode_select};
        port_io_pkg::OFS_OUTPUT_LATCH: next_rdata = {16'h0000, output_latch};
        port_io_pkg::OFS_DRIVE_STRENGTH: next_rdata = {16'h0000, pin_drive_strength_select};
        port_io_pkg::OFS_CONTROL: next_rdata = {30'h0000_0000, global_pullup_disable,
                                                pin_switch_enable};
        port_io_pkg::OFS_PIN_READ: next_rdata = {16'h0000, pin_read};
        port_io_pkg::OFS_SWITCH_SKIP: next_rdata = {16'h0000, switch_skip};
        port_io_pkg::OFS_CHAN_ENABLE: next_rdata = {28'h0000000, chan_enable};
        port_io_pkg::OFS_CLAIMED: next_rdata = {16'h0000, claimed};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      dphase_write <= 1'b0;
      dphase_addr <= 8'h00;
      rdata <= 32'h0000_0000;
    end else begin
      dphase_write <= next_dphase_write;
      dphase_addr <= next_dphase_addr;
      rdata <= next_rdata;
    end
  end

  assign HRDATA_O = rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = port_io_pkg::HRESP_OKAY;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    next_pin_analog_digital_select = pin_analog_digital_select;
    next_pin_output_mode_select = pin_output_mode_select;
    next_output_latch = output_latch;
    next_pin_drive_strength_select = pin_drive_strength_select;
    next_pin_switch_enable = pin_switch_enable;
    next_global_pullup_disable = global_pullup_disable;
    next_switch_skip = switch_skip;
    next_chan_enable = chan_enable;
    if (dphase_write) begin
      unique case (dphase_addr)
        port_io_pkg::OFS_ANALOG_DIGITAL: next_pin_analog_digital_select = HWDATA_I[15:0];
        port_io_pkg::OFS_OUTPUT_MODE: next_pin_output_mode_select = HWDATA_I[15:0];
        port_io_pkg::OFS_OUTPUT_LATCH: next_output_latch = HWDATA_I[15:0];
        port_io_pkg::OFS_DRIVE_STRENGTH: next_pin_drive_strength_select = HWDATA_I[15:0];
        port_io_pkg::OFS_CONTROL: begin
          next_pin_switch_enable = HWDATA_I[port_io_pkg::CTRL_SWITCH_EN_BIT];
          next_global_pullup_disable = HWDATA_I[port_io_pkg::CTRL_PULLUP_DIS_BIT];
        end
        port_io_pkg::OFS_SWITCH_SKIP: next_switch_skip = HWDATA_I[15:0];
        port_io_pkg::OFS_CHAN_ENABLE: next_chan_enable = HWDATA_I[3:0];
        default: next_chan_enable = chan_enable;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      pin_analog_digital_select <= port_io_pkg::RST_ANALOG_DIGITAL;
      pin_output_mode_select <= port_io_pkg::RST_OUTPUT_MODE;
      output_latch <= port_io_pkg::RST_OUTPUT_LATCH;
      pin_drive_strength_select <= port_io_pkg::RST_DRIVE_STRENGTH;
      pin_switch_enable <= port_io_pkg::RST_CONTROL[port_io_pkg::CTRL_SWITCH_EN_BIT];
      global_pullup_disable <= port_io_pkg::RST_CONTROL[port_io_pkg::CTRL_PULLUP_DIS_BIT];
      switch_skip <= port_io_pkg::RST_SWITCH_SKIP;
      chan_enable <= port_io_pkg::RST_CHAN_ENABLE;
    end else begin
      pin_analog_digital_select <= next_pin_analog_digital_select;
      pin_output_mode_select <= next_pin_output_mode_select;
      output_latch <= next_output_latch;
      pin_drive_strength_select <= next_pin_drive_strength_select;
      pin_switch_enable <= next_pin_switch_enable;
      global_pullup_disable <= next_global_pullup_disable;
      switch_skip <= next_switch_skip;
      chan_enable <= next_chan_enable;
    end
  end

endmodule

`default_nettype wire

// >>> testbench/port_io_cells_assertions.sv
/*
  Checker of pad relations and reset state of the port cell block.
  Assumes it is bound into port_io_cells and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module port_io_cells_assertions (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // pads and debug line
  input wire logic [15:0] PAD_IN_I,
  input wire logic [15:0] PAD_OUT_O,
  input wire logic [15:0] PAD_OE_N_O,
  input wire logic [15:0] PAD_PULLUP_EN_O,
  input wire logic [15:0] PAD_RX_EN_O,
  input wire logic [15:0] PAD_DRIVE_HIGH_O,
  input wire logic [3:0] PERIPH_IN_O,
  input wire logic DEBUG_WIRE_DATA_LINE_OE_I,
  input wire logic DEBUG_WIRE_DATA_LINE_OUT_I,
  input wire logic DEBUG_WIRE_DATA_LINE_IN_O
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // reset checks keep running while reset is high, the rest pause
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  property p_reset_state;
    disable iff (1'b0) SYS_RST_I |=> PAD_OE_N_O == 16'hffff && PAD_PULLUP_EN_O == 16'hffff
      && PAD_RX_EN_O == 16'hffff;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad pad state after reset");
  property p_reset_low;
    disable iff (1'b0) SYS_RST_I |=> PAD_DRIVE_HIGH_O == 16'h0000 && PERIPH_IN_O == 4'h0;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("drive strength not low at reset");
  property p_analog_pullup;
    (PAD_PULLUP_EN_O & ~PAD_RX_EN_O) == 16'h0000;
  endproperty
  a_analog_pullup: assert property (p_analog_pullup) else $error("pull-up on analog pin");
  property p_low_pullup;
    (PAD_PULLUP_EN_O & ~PAD_OE_N_O & ~PAD_OUT_O) == 16'h0000;
  endproperty
  a_low_pullup: assert property (p_low_pullup) else $error("pull-up while driving low");
  property p_high_driven;
    (PAD_OUT_O & PAD_OE_N_O) == 16'h0000;
  endproperty
  a_high_driven: assert property (p_high_driven) else $error("high level with driver off");
  property p_debug_digital;
    PAD_RX_EN_O[15];
  endproperty
  a_debug_digital: assert property (p_debug_digital) else $error("shared pin not digital");
  property p_debug_read;
    !SYS_RST_I |=> DEBUG_WIRE_DATA_LINE_IN_O == $past(PAD_IN_I[15]);
  endproperty
  a_debug_read: assert property (p_debug_read) else $error("debug line level wrong");
  property p_debug_drive;
    DEBUG_WIRE_DATA_LINE_OE_I |=> !PAD_OE_N_O[15]
      && PAD_OUT_O[15] == $past(DEBUG_WIRE_DATA_LINE_OUT_I);
  endproperty
  a_debug_drive: assert property (p_debug_drive) else $error("debug drive not on pad");
endmodule

bind port_io_cells port_io_cells_assertions chk_u (.REF_CLK_I, .SYS_RST_I, .PAD_IN_I,
  .PAD_OUT_O, .PAD_OE_N_O, .PAD_PULLUP_EN_O, .PAD_RX_EN_O, .PAD_DRIVE_HIGH_O, .PERIPH_IN_O,
  .DEBUG_WIRE_DATA_LINE_OE_I, .DEBUG_WIRE_DATA_LINE_OUT_I, .DEBUG_WIRE_DATA_LINE_IN_O);

`default_nettype wire

// >>> testbench/port_io_pad_model.sv
/*
  External circuits on the sixteen pads: resolves each pad level.
  Assumes pad outputs of the cell block and an optional external drive.
*/
`timescale 1ns/1ps
`default_nettype none

module port_io_pad_model (
  // clock
  input wire logic clk_i,
  // cell side and external drive
  input wire logic [15:0] out_i,
  input wire logic [15:0] oe_n_i,
  input wire logic [15:0] pullup_i,
  input wire logic [15:0] ext_en_i,
  input wire logic [15:0] ext_val_i,
  // resolved level
  output logic [15:0] pad_o
);
  // ----------------------------------------------------------------
  // pad resolution
  // ----------------------------------------------------------------
  logic tog = 1'b0;
  always @(posedge clk_i) tog <= ~tog;
  // a floating pad toggles so that a stale level never passes as valid
  always_comb pad_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_val_i)
    | (oe_n_i & ~ext_en_i & (pullup_i | {16{tog}}));
endmodule

`default_nettype wire

// >>> testbench/port_io_cells_bench.sv
/*
  Self-checking bench of the port cell block over AHB-Lite.
  Assumes the pad model and the bound checker beside the design.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end

module port_io_cells_bench;
  logic clk, rst, hsel, hwrite, hready, hresp, dbg_oe, dbg_out, dbg_in;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [15:0] pad, out, oe_n, pu, rx, dh, ext_en, ext_val;
  logic [3:0] pout, pin;
  int bad_count = 0;
  int n_tests = 0;

  // ----------------------------------------------------------------
  // clock, design and pads
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  port_io_cells dut_u (.REF_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .PAD_IN_I(pad), .PAD_OUT_O(out), .PAD_OE_N_O(oe_n), .PAD_PULLUP_EN_O(pu),
    .PAD_RX_EN_O(rx), .PAD_DRIVE_HIGH_O(dh), .PERIPH_OUT_I(pout), .PERIPH_IN_O(pin),
    .DEBUG_WIRE_DATA_LINE_OE_I(dbg_oe), .DEBUG_WIRE_DATA_LINE_OUT_I(dbg_out),
    .DEBUG_WIRE_DATA_LINE_IN_O(dbg_in));
  port_io_pad_model pad_u (.clk_i(clk), .out_i(out), .oe_n_i(oe_n), .pullup_i(pu),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // bounded wait for ready; the watchdog covers a hung slave too
  task automatic wt();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= port_io_pkg::HTRANS_NONSEQ;
    hwrite <= 1'b1;
    haddr <= {24'h000000, a};
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= port_io_pkg::HTRANS_NONSEQ;
    hwrite <= 1'b0;
    haddr <= {24'h000000, a};
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wt();
    v = hrdata;
    `CHK(v, e)
    `CHK(hresp, port_io_pkg::HRESP_OKAY)
  endtask
  // register write lands, then pads follow one edge later
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    settle();
    `CHK({oe_n, pu, rx}, 48'hffff_ffff_ffff)
    `CHK(dh, 16'h0000)
    rd(port_io_pkg::OFS_ANALOG_DIGITAL, 32'h0000ffff);
    rd(port_io_pkg::OFS_DRIVE_STRENGTH, 32'h00000000);
    rd(port_io_pkg::OFS_PIN_READ, 32'h0000ffff);
    rd(8'h40, 32'h00000000);
    $display("reset test done");
  endtask
  task automatic t_push();
    wr(port_io_pkg::OFS_OUTPUT_MODE, 32'h0000ffff);
    wr(port_io_pkg::OFS_OUTPUT_LATCH, 32'h00000000);
    settle();
    `CHK(oe_n, 16'hffff)
    wr(port_io_pkg::OFS_CONTROL, 32'h00000001);
    settle();
    `CHK({oe_n, out, pu}, 48'h0)
    wr(port_io_pkg::OFS_OUTPUT_LATCH, 32'h000000ff);
    wr(port_io_pkg::OFS_DRIVE_STRENGTH, 32'h00000003);
    settle();
    `CHK({oe_n, out}, 32'h0000_00ff)
    `CHK(dh, 16'h0003)
    $display("push-pull test done");
  endtask
  task automatic t_drain();
    ext_en <= 16'h0001;
    ext_val <= 16'h0000;
    wr(port_io_pkg::OFS_OUTPUT_MODE, 32'h00000000);
    settle();
    `CHK({oe_n, out}, 32'h00ff_0000)
    `CHK(pu, 16'h00ff)
    rd(port_io_pkg::OFS_PIN_READ, 32'h000000fe);
    wr(port_io_pkg::OFS_CONTROL, 32'h00000003);
    settle();
    `CHK(pu, 16'h0000)
    $display("open-drain test done");
  endtask
  task automatic t_analog();
    ext_en <= 16'hffff;
    ext_val <= 16'hffff;
    wr(port_io_pkg::OFS_CONTROL, 32'h00000001);
    wr(port_io_pkg::OFS_OUTPUT_LATCH, 32'h0000ffff);
    wr(port_io_pkg::OFS_ANALOG_DIGITAL, 32'h00000000);
    settle();
    `CHK({rx, pu}, 32'h8000_8000)
    rd(port_io_pkg::OFS_ANALOG_DIGITAL, 32'h00008000);
    rd(port_io_pkg::OFS_PIN_READ, 32'h00008000);
    wr(port_io_pkg::OFS_ANALOG_DIGITAL, 32'h0000ffff);
    settle();
    rd(port_io_pkg::OFS_PIN_READ, 32'h0000ffff);
    $display("analog test done");
  endtask
  task automatic t_switch();
    pout <= 4'h4;
    wr(port_io_pkg::OFS_CHAN_ENABLE, 32'h00000001);
    settle();
    rd(port_io_pkg::OFS_CLAIMED, 32'h00000001);
    wr(port_io_pkg::OFS_SWITCH_SKIP, 32'h00000003);
    settle();
    rd(port_io_pkg::OFS_CLAIMED, 32'h00000004);
    `CHK(oe_n[2:0], 3'b011)
    `CHK(pin[0], 1'b0)
    $display("pin switch test done");
  endtask
  task automatic t_debug();
    ext_en <= 16'h7fff;
    dbg_oe <= 1'b1;
    dbg_out <= 1'b0;
    settle();
    @(posedge clk);
    #1;
    `CHK({oe_n[15], out[15], dbg_in}, 3'b000)
    dbg_oe <= 1'b0;
    $display("debug line test done");
  endtask

  // ----------------------------------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst, hsel, hwrite, dbg_oe, dbg_out, htrans} = 7'h40;
    {haddr, hwdata} = 64'h0;
    {ext_en, ext_val, pout} = 36'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_push();
    t_drain();
    t_analog();
    t_switch();
    t_debug();
    results();
  end
  // the run needs about a hundred cycles; far beyond that it has hung
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule

`default_nettype wire
